/* File: hdl/csl_map.svh */
// Constants for the communicator status LED controller
`ifndef CSL_MAP_SVH
`define CSL_MAP_SVH
// ---------------------------------------------------------------
// APB register byte addresses
// ---------------------------------------------------------------
`define CSL_ADDR_TRBL     12'h000
`define CSL_ADDR_NET      12'h004
`define CSL_ADDR_CSQ      12'h008
`define CSL_ADDR_MODE     12'h00C
`define CSL_ADDR_EVENT    12'h010
`define CSL_ADDR_STATUS   12'h014
// ---------------------------------------------------------------
// Trouble register bit positions
// ---------------------------------------------------------------
`define CSL_TB_RSUP_EN    0
`define CSL_TB_HB_MISS    1
`define CSL_TB_ETH1_SUP   2
`define CSL_TB_ETH1_NOHB  3
`define CSL_TB_EXHAUST    4
`define CSL_TB_CFGFAIL    5
`define CSL_TB_ACCT       6
`define CSL_TB_RX_UNPROG  7
// ---------------------------------------------------------------
// Network register bit positions
// ---------------------------------------------------------------
`define CSL_NB_UNPLUG     0
`define CSL_NB_DHCP_TO    1
`define CSL_NB_NO_IP      2
`define CSL_NB_CELL_RST   3
`define CSL_NB_LINK_UP    4
`define CSL_NB_DUAL       5
// ---------------------------------------------------------------
// Mode register bit positions
// ---------------------------------------------------------------
`define CSL_MB_FW_START   0
`define CSL_MB_FW_BUSY    1
`define CSL_MB_FW_DONE    2
`define CSL_MB_FW_FAIL    3
// ---------------------------------------------------------------
// Event register bit positions (write one to fire)
// ---------------------------------------------------------------
`define CSL_EB_ETH_TX     0
`define CSL_EB_ETH_RX     1
`define CSL_EB_CELL_TX    2
`define CSL_EB_CELL_RX    3
// ---------------------------------------------------------------
// Timing (250 MHz)
// ---------------------------------------------------------------
`define CSL_CLK_MHZ       250
`define CSL_PULSE_MS      100
`define CSL_FAIL_MS       1000
`define CSL_CODE_GAP      4'h4
`define CSL_CSQ_LOW       5'h05
`define CSL_TROUBLE_NONE  4'h0
`define CSL_FLASH_CELL    4'h5
`define CSL_FLASH_RSUP    4'h8
`define CSL_FLASH_EXH     4'h9
`define CSL_FLASH_CFG     4'hA
`define CSL_FLASH_FWUP    4'hB
`define CSL_FLASH_ACCT    4'hC
`endif

/* File: hdl/csl_pkg.sv */
// Types for the communicator status LED controller
package csl_pkg;
    typedef enum logic [4:0] {
        CSL_FW_IDLE  = 5'h01,
        CSL_FW_START = 5'h02,
        CSL_FW_CHASE = 5'h04,
        CSL_FW_FAIL  = 5'h08,
        CSL_FW_BOOT  = 5'h10
    } csl_fw_e;
    typedef struct packed {
        logic yellow;
        logic red;
        logic green1;
        logic green2;
        logic link;
    } csl_leds_s;
endpackage

/* File: hdl/csl_led_ctrl.sv */
// Status LED controller with APB register access
//
// Added by the designer: the APB register port and the register offsets.
`include "csl_map.svh"
// What this block does
// - Cellular supervision with four unanswered heartbeats raises eight-flash trouble.
// - Supervised wired path missing receiver heartbeat also raises eight-flash trouble.
// - All delivery attempts exhausted raises nine-flash trouble.
// - Failed remote programming shows ten yellow flashes.
// - Firmware upgrade in progress shows eleven flashes, clearing on success.
// - Unprogrammed account codes show twelve flashes; disabled receivers ignored.
// - Red LED pulses once per wired send, twice per acknowledgement received.
// - Red LED steady on for unplugged, timeout, no address or cellular reset.
// - Signal meter hidden while yellow flashes a code.
// - CSQ 0, 1-4 and 5-6 map onto yellow and green 1 patterns.
// - CSQ 7-10, 11-13 and 14 up light greens progressively.
// - Averaged CSQ of five or lower raises five-flash cellular trouble.
// - Dual-path: green 2 pulses once per cellular send, twice per reception.
// - Wired-only: link LED lit while wired connection active.
// - Jumper at power-up restores defaults, greens flash rapidly while fitted.
// - Rapid green flashing stops once jumper removed.
// - Firmware update start lights all LEDs.
// - During update, LEDs light one at a time in a chaser.
// - Successful update restarts the device automatically.
// - Failed update blinks all four LEDs together at one second intervals.
// - Only the fewest-flash active trouble shows; next follows; off when none.
module csl_led_ctrl
    import csl_pkg::*;
#(
    parameter int unsigned PULSE_CYC = `CSL_CLK_MHZ * 1000 * `CSL_PULSE_MS,
    parameter int unsigned FAIL_CYC  = `CSL_CLK_MHZ * 1000 * `CSL_FAIL_MS
)(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        clk_en,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        default_jumper_header,
    output logic             led_yellow,
    output logic             led_red,
    output logic             led_green1,
    output logic             led_green2,
    output logic             led_link,
    output logic             factory_restore,
    output logic             self_restart
);
    // ---------------------------------------------------------------
    // APB slave
    // ---------------------------------------------------------------
    logic [7:0]  trbl_reg;
    logic [5:0]  net_reg;
    logic [4:0]  csq_reg;
    logic [3:0]  mode_reg;
    logic [31:0] rdata_next;
    wire  acc      = psel && penable && clk_en;
    wire  wr       = acc && pwrite;
    wire  sel_trbl = paddr == `CSL_ADDR_TRBL;
    wire  sel_net  = paddr == `CSL_ADDR_NET;
    wire  sel_csq  = paddr == `CSL_ADDR_CSQ;
    wire  sel_mode = paddr == `CSL_ADDR_MODE;
    wire  sel_evt  = paddr == `CSL_ADDR_EVENT;
    wire  sel_stat = paddr == `CSL_ADDR_STATUS;
    wire  mapped   = sel_trbl | sel_net | sel_csq | sel_mode | sel_evt | sel_stat;
    wire  [3:0] evt = (wr && sel_evt) ? pwdata[3:0] : 4'h0;
    csl_fw_e    fw_reg;
    logic [3:0] code_reg;
    logic       dflt_reg;
    csl_leds_s  led_next;

    always_comb
    begin
        rdata_next = 32'h0;
        if (sel_trbl)
            rdata_next = {24'h0, trbl_reg};
        else if (sel_net)
            rdata_next = {26'h0, net_reg};
        else if (sel_csq)
            rdata_next = {27'h0, csq_reg};
        else if (sel_mode)
            rdata_next = {28'h0, mode_reg};
        else if (sel_stat)
            rdata_next = {17'h0, fw_reg, dflt_reg, code_reg, led_next};
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            trbl_reg <= 8'h0;
            net_reg  <= 6'h0;
            csq_reg  <= 5'h0;
            mode_reg <= 4'h0;
            prdata   <= 32'h0;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
        end
        else if (clk_en)
        begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            if (psel && !penable && !pwrite)
                prdata <= rdata_next;
            if (wr && sel_trbl)
                trbl_reg <= pwdata[7:0];
            if (wr && sel_net)
                net_reg <= pwdata[5:0];
            if (wr && sel_csq)
                csq_reg <= pwdata[4:0];
            if (wr && sel_mode)
                mode_reg <= pwdata[3:0];
            else if (fw_reg == CSL_FW_BOOT)
                mode_reg <= 4'h0;
        end
    end
    // ---------------------------------------------------------------
    // Trouble selection
    // ---------------------------------------------------------------
    wire t_cell = csq_reg <= `CSL_CSQ_LOW;
    wire t_rsup = (trbl_reg[`CSL_TB_RSUP_EN] && trbl_reg[`CSL_TB_HB_MISS])
               || (trbl_reg[`CSL_TB_ETH1_SUP] && trbl_reg[`CSL_TB_ETH1_NOHB]);
    wire t_exh  = trbl_reg[`CSL_TB_EXHAUST];
    wire t_cfg  = trbl_reg[`CSL_TB_CFGFAIL];
    wire t_fwup = mode_reg[`CSL_MB_FW_BUSY];
    wire t_acct = trbl_reg[`CSL_TB_ACCT] || trbl_reg[`CSL_TB_RX_UNPROG];
    // Fewest flashes wins
    wire [3:0] code_next = t_cell ? `CSL_FLASH_CELL : t_rsup ? `CSL_FLASH_RSUP :
                           t_exh ? `CSL_FLASH_EXH : t_cfg ? `CSL_FLASH_CFG :
                           t_fwup ? `CSL_FLASH_FWUP : t_acct ? `CSL_FLASH_ACCT : `CSL_TROUBLE_NONE;

    // ---------------------------------------------------------------
    // Timebase and flash sequencer
    // ---------------------------------------------------------------
    logic [31:0] tick_cnt;
    logic        tick;
    logic        phase_reg;
    logic [3:0]  fl_cnt;
    logic        gap_reg;
    logic        yflash;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            tick_cnt  <= 32'h0;
            tick      <= 1'b0;
            phase_reg <= 1'b0;
            fl_cnt    <= 4'h0;
            gap_reg   <= 1'b0;
            yflash    <= 1'b0;
            code_reg  <= 4'h0;
        end
        else if (clk_en)
        begin
            tick     <= tick_cnt == PULSE_CYC - 1;
            tick_cnt <= (tick_cnt == PULSE_CYC - 1) ? 32'h0 : tick_cnt + 32'h1;
            if (code_next != code_reg)
            begin
                code_reg <= code_next;
                fl_cnt   <= 4'h0;
                gap_reg  <= 1'b0;
                yflash   <= 1'b0;
            end
            else if (tick)
            begin
                phase_reg <= !phase_reg;
                if (code_reg == `CSL_TROUBLE_NONE)
                    yflash <= 1'b0;
                else if (gap_reg)
                begin
                    fl_cnt <= fl_cnt + 4'h1;
                    if (fl_cnt == `CSL_CODE_GAP)
                    begin
                        gap_reg <= 1'b0;
                        fl_cnt  <= 4'h0;
                    end
                end
                else if (!yflash)
                    yflash <= 1'b1;
                else
                begin
                    yflash <= 1'b0;
                    fl_cnt <= fl_cnt + 4'h1;
                    if (fl_cnt == code_reg - 4'h1)
                    begin
                        gap_reg <= 1'b1;
                        fl_cnt  <= 4'h0;
                    end
                end
            end
        end
    end
    // ---------------------------------------------------------------
    // Activity pulse trains: red for wired, green 2 for cellular
    // ---------------------------------------------------------------
    logic [1:0] act_cnt [2];
    logic [1:0] act_on;
    logic [1:0] act_pend [2];
    genvar g;
    generate
        for (g = 0; g < 2; g++)
        begin : g_act
            always_ff @(posedge pclk or negedge presetn)
            begin
                if (!presetn)
                begin
                    act_cnt[g]  <= 2'h0;
                    act_on[g]   <= 1'b0;
                    act_pend[g] <= 2'h0;
                end
                else if (clk_en)
                begin
                    if (evt[2*g+1])
                        act_pend[g] <= 2'h2;
                    else if (evt[2*g] && act_pend[g] == 2'h0)
                        act_pend[g] <= 2'h1;
                    if (tick)
                    begin
                        if (act_on[g])
                            act_on[g] <= 1'b0;
                        else if (act_cnt[g] != 2'h0)
                        begin
                            act_on[g]  <= 1'b1;
                            act_cnt[g] <= act_cnt[g] - 2'h1;
                        end
                        else if (act_pend[g] != 2'h0 && !evt[2*g+1] && !evt[2*g])
                        begin
                            act_cnt[g]  <= act_pend[g];
                            act_pend[g] <= 2'h0;
                        end
                    end
                end
            end
        end
    endgenerate
    // ---------------------------------------------------------------
    // Default jumper and firmware update sequencer
    // ---------------------------------------------------------------
    logic        strap_done;
    logic [31:0] fail_cnt;
    logic        fail_on;
    logic [1:0]  chase_reg;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            strap_done      <= 1'b0;
            dflt_reg        <= 1'b0;
            factory_restore <= 1'b0;
            self_restart    <= 1'b0;
            fw_reg          <= CSL_FW_IDLE;
            fail_cnt        <= 32'h0;
            fail_on         <= 1'b0;
            chase_reg       <= 2'h0;
        end
        else if (clk_en)
        begin
            strap_done      <= 1'b1;
            factory_restore <= !strap_done && default_jumper_header;
            if (!strap_done)
                dflt_reg <= default_jumper_header;
            else if (!default_jumper_header)
                dflt_reg <= 1'b0;
            self_restart <= fw_reg == CSL_FW_BOOT;
            if (tick)
                chase_reg <= chase_reg + 2'h1;
            fail_cnt <= (fail_cnt == FAIL_CYC - 1) ? 32'h0 : fail_cnt + 32'h1;
            if (fail_cnt == FAIL_CYC - 1)
                fail_on <= !fail_on;
            case (fw_reg)
                CSL_FW_IDLE:
                    if (mode_reg[`CSL_MB_FW_START])
                        fw_reg <= CSL_FW_START;
                CSL_FW_START:
                    if (mode_reg[`CSL_MB_FW_BUSY])
                        fw_reg <= CSL_FW_CHASE;
                CSL_FW_CHASE:
                    if (mode_reg[`CSL_MB_FW_FAIL])
                    begin
                        fw_reg   <= CSL_FW_FAIL;
                        fail_cnt <= 32'h0;
                        fail_on  <= 1'b1;
                    end
                    else if (mode_reg[`CSL_MB_FW_DONE])
                        fw_reg <= CSL_FW_BOOT;
                CSL_FW_FAIL:
                    fw_reg <= CSL_FW_FAIL;
                CSL_FW_BOOT:
                    fw_reg <= CSL_FW_IDLE;
                default:
                    fw_reg <= CSL_FW_IDLE;
            endcase
        end
    end
    // ---------------------------------------------------------------
    // LED composition
    // ---------------------------------------------------------------
    wire       cq0   = csq_reg == 5'h0;
    wire       cq14  = csq_reg > 5'hD;
    wire       cq11  = csq_reg > 5'hA;
    wire       cq7   = csq_reg > 5'h6;
    wire       cq5   = csq_reg > 5'h4;
    wire       red_s = |net_reg[`CSL_NB_CELL_RST:`CSL_NB_UNPLUG];
    wire       dual  = net_reg[`CSL_NB_DUAL];
    always_comb
    begin
        led_next.link   = !dual && net_reg[`CSL_NB_LINK_UP];
        led_next.red    = red_s || act_on[0];
        if (code_reg != `CSL_TROUBLE_NONE)
        begin
            led_next.yellow = yflash;
            led_next.green1 = 1'b0;
            led_next.green2 = 1'b0;
        end
        else
        begin
            led_next.yellow = !cq5;
            led_next.green1 = cq7 || (!cq0 && phase_reg);
            led_next.green2 = cq14 || (cq11 && phase_reg);
        end
        if (dual && act_on[1])
            led_next.green2 = 1'b1;
        if (dflt_reg)
        begin
            led_next.green1 = phase_reg;
            led_next.green2 = phase_reg;
        end
        case (fw_reg)
            CSL_FW_START:
                led_next = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1};
            CSL_FW_CHASE:
                led_next = '{chase_reg == 2'h0, chase_reg == 2'h1, chase_reg == 2'h2,
                             chase_reg == 2'h3, 1'b0};
            CSL_FW_FAIL:
                led_next = '{fail_on, fail_on, fail_on, fail_on, 1'b0};
            default:
                ;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            led_yellow <= 1'b0;
            led_red    <= 1'b0;
            led_green1 <= 1'b0;
            led_green2 <= 1'b0;
            led_link   <= 1'b0;
        end
        else if (clk_en)
        begin
            led_yellow <= led_next.yellow;
            led_red    <= led_next.red;
            led_green1 <= led_next.green1;
            led_green2 <= led_next.green2;
            led_link   <= led_next.link;
        end
    end
    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    property p_red_steady;
        @(posedge pclk) disable iff (!presetn)
        clk_en && red_s && fw_reg == CSL_FW_IDLE |=> led_red;
    endproperty
    a_red_steady: assert property (p_red_steady) else $error("red not steady");
    property p_cell_code;
        @(posedge pclk) disable iff (!presetn)
        clk_en && t_cell |=> code_reg == `CSL_FLASH_CELL;
    endproperty
    a_cell_code: assert property (p_cell_code) else $error("cell code wrong");
    property p_start_all;
        @(posedge pclk) disable iff (!presetn)
        clk_en && fw_reg == CSL_FW_START |=> led_yellow && led_red && led_green1 && led_green2;
    endproperty
    a_start_all: assert property (p_start_all) else $error("start not all on");
    property p_fail_unison;
        @(posedge pclk) disable iff (!presetn)
        $past(fw_reg) == CSL_FW_FAIL && $past(clk_en) |-> led_yellow == led_green1 && led_red == led_green2;
    endproperty
    a_fail_unison: assert property (p_fail_unison) else $error("fail not unison");
    property p_meter_hidden;
        @(posedge pclk) disable iff (!presetn)
        clk_en && code_reg != 4'h0 && fw_reg == CSL_FW_IDLE && !dflt_reg && !dual |=> !led_green1;
    endproperty
    a_meter_hidden: assert property (p_meter_hidden) else $error("meter shown");
    property p_dflt_stop;
        @(posedge pclk) disable iff (!presetn)
        clk_en && strap_done && !default_jumper_header |=> !dflt_reg;
    endproperty
    a_dflt_stop: assert property (p_dflt_stop) else $error("default not stopped");
    property p_restart;
        @(posedge pclk) disable iff (!presetn)
        clk_en && fw_reg == CSL_FW_CHASE && mode_reg[`CSL_MB_FW_DONE] && !mode_reg[`CSL_MB_FW_FAIL]
        ##1 clk_en |=> self_restart;
    endproperty
    a_restart: assert property (p_restart) else $error("no restart");
    property p_priority;
        @(posedge pclk) disable iff (!presetn)
        clk_en && t_rsup && !t_cell |=> code_reg == `CSL_FLASH_RSUP;
    endproperty
    a_priority: assert property (p_priority) else $error("priority wrong");
    c_fail: cover property (@(posedge pclk) fw_reg == CSL_FW_FAIL);
    c_restart: cover property (@(posedge pclk) self_restart);
    c_code: cover property (@(posedge pclk) gap_reg && code_reg == `CSL_FLASH_EXH);
endmodule // csl_led_ctrl

/* File: verif/csl_led_watch.sv */
// Installer model: counts the flashes of each yellow burst
module csl_led_watch #(
    parameter int GAP = 10
)(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       led,
    output logic      [4:0] burst
);
    timeunit 1ns;
    timeprecision 1ps;
    int         off_cnt;
    logic [4:0] run;
    logic       led_q;
    // Long dark spell closes a burst
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            off_cnt <= 0;
            run     <= 5'h00;
            led_q   <= 1'b0;
            burst   <= 5'h00;
        end
        else
        begin
            led_q   <= led;
            off_cnt <= led ? 0 : off_cnt + 1;
            if (led && !led_q)
                run <= run + 5'h01;
            if (!led && off_cnt == GAP && run != 5'h00)
            begin
                burst <= run;
                run   <= 5'h00;
            end
        end
    end
endmodule // csl_led_watch

/* File: verif/tb_top.sv */
// Self-checking bench for the status LED controller
`include "csl_map.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    import csl_pkg::*;
    logic        pclk, presetn, clk_en, psel, penable, pwrite, jumper;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic        pready, pslverr, err, y, r, g1, g2, lk, restore, restart, ok, pv;
    logic [4:0]  burst;
    int          bad_count, compares, c, i, q;
    logic [15:0] tbl [9] = '{16'h1403, 16'h140C, 16'h1430, 16'h1420, 16'h1440,
                             16'h1480, 16'h1401, 16'h0500, 16'h0530};
    csl_led_ctrl #(.PULSE_CYC(4), .FAIL_CYC(10)) dut (.pclk(pclk), .presetn(presetn), .clk_en(clk_en),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .default_jumper_header(jumper), .led_yellow(y), .led_red(r),
        .led_green1(g1), .led_green2(g2), .led_link(lk), .factory_restore(restore), .self_restart(restart));
    csl_led_watch #(.GAP(10)) obs (.pclk(pclk), .presetn(presetn), .led(y), .burst(burst));
    always #2 pclk = ~pclk;
    function automatic int exp_code(input int t, input int s);
        return (s <= 5) ? 5 : ((t & 3) == 3 || (t & 12) == 12) ? 8 : t[4] ? 9 : t[5] ? 10 : (t & 192) ? 12 : 0;
    endfunction
    task automatic wrap_up();
        if (bad_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e)
        begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            n++;
        end
        while (pready !== 1'b1 && n < 50);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50)
        begin
            bad_count++;
            wrap_up();
        end
    endtask
    task automatic rises(input logic red, output int k);
        logic p, v;
        k = 0;
        p = 0;
        repeat (80)
        begin
            @(posedge pclk);
            v = red ? r : g2;
            if (v && !p)
                k++;
            p = v;
        end
    endtask
    initial
    begin
        pclk = 0; presetn = 0; clk_en = 1; psel = 0; penable = 0; pwrite = 0;
        paddr = 12'h000; pwdata = 32'h0; jumper = 1; bad_count = 0; compares = 0;
        void'($urandom(32'hEF7735BF));
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        ok = 0;
        repeat (4) @(posedge pclk) if (restore === 1'b1) ok = 1;
        chk("restore", 1, ok);
        c = 0;
        ok = 1;
        pv = g1;
        repeat (40) @(posedge pclk)
        begin
            if (g1 !== g2)
                ok = 0;
            if (g1 !== pv)
                c++;
            pv = g1;
        end
        chk("dflt_flash", 1, ok && c > 0);
        jumper <= 1'b0;
        for (i = 0; i < 4; i++)
        begin
            q = $urandom_range(0, 1) ? 7 + $urandom_range(0, 3) : 14 + $urandom_range(0, 17);
            apb(1, `CSL_ADDR_CSQ, q);
            apb(0, `CSL_ADDR_CSQ, 0);
            chk("csq_reg", q, rd[4:0]);
            repeat (20) @(posedge pclk);
            chk("meter", {1'b0, q >= 14, 1'b1}, {y, g2, g1});
        end
        apb(1, `CSL_ADDR_CSQ, 32'h6);
        repeat (3) @(posedge pclk);
        c = 0;
        ok = 1;
        pv = g1;
        repeat (40) @(posedge pclk)
        begin
            if ({y, g2} !== 2'b00)
                ok = 0;
            if (g1 !== pv)
                c++;
            pv = g1;
        end
        chk("csq6", 1, ok && c > 0);
        for (i = 0; i < 9; i++)
        begin
            apb(1, `CSL_ADDR_CSQ, tbl[i][15:8]);
            apb(1, `CSL_ADDR_TRBL, tbl[i][7:0]);
            repeat (400) @(posedge pclk);
            if (exp_code(tbl[i][7:0], tbl[i][15:8]) == 0)
                chk("yellow", 0, y);
            else
                chk("flashes", exp_code(tbl[i][7:0], tbl[i][15:8]), burst);
        end
        apb(1, `CSL_ADDR_TRBL, 0);
        apb(1, `CSL_ADDR_CSQ, 8);
        apb(1, `CSL_ADDR_NET, 32'h1);
        repeat (4) @(posedge pclk);
        chk("red_on", 1, r);
        apb(1, `CSL_ADDR_NET, 32'h10);
        repeat (4) @(posedge pclk);
        chk("red_off_link", 2'b01, {r, lk});
        apb(1, `CSL_ADDR_NET, 32'h20);
        for (i = 0; i < 4; i++)
        begin
            apb(1, `CSL_ADDR_EVENT, 32'h1 << i);
            rises(i < 2, c);
            chk("activity", i % 2 + 1, c);
        end
        apb(1, 12'h020, 32'h5);
        chk("unmapped_wr", 1, err);
        apb(0, 12'h020, 32'h0);
        chk("unmapped_err", 1, err);
        chk("unmapped_rd", 0, rd);
        apb(1, `CSL_ADDR_MODE, 32'h1);
        repeat (4) @(posedge pclk);
        chk("fw_start", 4'hF, {y, r, g1, g2});
        apb(1, `CSL_ADDR_MODE, 32'h2);
        repeat (3) @(posedge pclk);
        c = 0;
        ok = 1;
        repeat (64) @(posedge pclk)
        begin
            if (y)
                c++;
            if ($countones({y, r, g1, g2}) != 1)
                ok = 0;
        end
        chk("chaser", 1, ok && c > 0 && c < 32);
        apb(0, `CSL_ADDR_STATUS, 32'h0);
        chk("fw_code", 11, rd[8:5]);
        apb(1, `CSL_ADDR_MODE, 32'h4);
        ok = 0;
        repeat (20) @(posedge pclk) if (restart === 1'b1) ok = 1;
        chk("restart", 1, ok);
        apb(1, `CSL_ADDR_MODE, 32'h1);
        apb(1, `CSL_ADDR_MODE, 32'h2);
        apb(1, `CSL_ADDR_MODE, 32'h8);
        repeat (3) @(posedge pclk);
        c = 0;
        ok = 1;
        pv = y;
        repeat (45) @(posedge pclk)
        begin
            if ({r, g1, g2} !== {3{y}})
                ok = 0;
            if (y !== pv)
                c++;
            pv = y;
        end
        chk("fw_fail", 1, ok && c >= 3 && c <= 5);
        clk_en <= 1'b0;
        @(posedge pclk);
        pv = y;
        ok = 1;
        repeat (20) @(posedge pclk)
            if (y !== pv)
                ok = 0;
        clk_en <= 1'b1;
        chk("freeze", 1, ok);
        wrap_up();
    end
endmodule // tb_top
